// *** hw/fmsp_pkg.sv ***
// Constants and types shared by the four-mode serial port
package fmsp_pkg;
  // Special function register addresses
  localparam logic [7:0] CTRL_ADDR = 8'h98;
  localparam logic [7:0] BUF_ADDR  = 8'h99;
  localparam logic [7:0] PWR_ADDR  = 8'h87;
  // serial_control_reg field positions
  localparam int RX_DONE_POS  = 0;
  localparam int TX_DONE_POS  = 1;
  localparam int RX_NINTH_POS = 2;
  localparam int TX_NINTH_POS = 3;
  localparam int REN_POS      = 4;
  localparam int MP_EN_POS    = 5;
  localparam int MODE_LO_POS  = 6;
  localparam int MODE_HI_POS  = 7;
  // power_control_reg field positions
  localparam int RATE_SEL_POS = 7;
  localparam int VIEW_SEL_POS = 6;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] PWR_RST  = 2'h0;
  // Mode encodings of {mode_sel_hi, mode_sel_lo}
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8VAR  = 2'h1;
  localparam logic [1:0] MODE_9FIX  = 2'h2;
  localparam logic [1:0] MODE_9VAR  = 2'h3;
  // Timing and framing counts
  localparam int M0_DIV   = 6;
  localparam int OVS_RATE = 16;
  localparam logic [3:0] M0_BITS = 4'h8;
  localparam logic [3:0] FRAME_8 = 4'ha;
  localparam logic [3:0] FRAME_9 = 4'hb;
  localparam logic [3:0] RX_LAST_8 = 4'h8;
  localparam logic [3:0] RX_LAST_9 = 4'h9;
  localparam logic [3:0] M0_LAST  = 4'h7;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT0, TX_ASYNC} fmsp_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT0, RX_START, RX_DATA} fmsp_rx_st_t;
endpackage : fmsp_pkg

// *** hw/fmsp_buf2.sv ***
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module fmsp_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_reg [2];
  logic             wptr_reg;
  logic             rptr_reg;
  logic [1:0]       cnt_reg;
  logic [1:0]       cnt_next;
  logic             ready_reg;
  logic             push;
  logic             pop;

  generate if (WIDTH < 1) begin : g_bad
    $error("fmsp_buf2: WIDTH must be positive");
  end endgenerate

  assign push        = in_valid_i && ready_reg;
  assign pop         = out_ready_i && (cnt_reg != 2'h0);
  assign cnt_next    = cnt_reg + {1'b0, push} - {1'b0, pop};
  // Ready comes straight from a flop so it can leave the block unchanged
  assign in_ready_o  = ready_reg;
  assign out_valid_o = cnt_reg != 2'h0;
  assign out_data_o  = mem_reg[rptr_reg];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg  <= 2'h0;
      ready_reg <= 1'b1;
    end else begin
      wptr_reg <= wptr_reg ^ push;
      rptr_reg <= rptr_reg ^ pop;
      cnt_reg  <= cnt_next;
      ready_reg <= cnt_next != 2'h2;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end
endmodule : fmsp_buf2

// *** hw/fmsp_serial_port.sv ***
// Four-mode serial port: shift register mode and three asynchronous modes
// How it works
// - Transmit and receive machines are separate and run at the same time in modes 1 to 3.
// - A new reception may start before the old byte is read; it overwrites.
// - Buffer writes feed the transmitter; buffer reads return a separate receive register.
// - Mode 0 moves 8 bits LSB first on the data pin, clock on transmit pin.
// - Mode 0 shift clock is one sixth of the CPU clock.
// - Mode 1 frame: low start bit, 8 data bits LSB first, high stop.
// - Mode 1 reception stores the stop bit in the received ninth bit.
// - Modes 1 and 3 take their bit rate from timer 1 overflow pulses.
// - Modes 2 and 3 frame: start, 8 data bits, ninth bit, stop.
// - Nine-bit transmit sends the transmit ninth bit field as ninth bit.
// - Nine-bit receive stores the ninth bit, not the stop bit.
// - Mode 2 rate is CPU clock over 16 or 32 by rate select.
// - A write to the serial buffer starts a transmission unless the two-entry queue is full, which drops it.
// - Mode 0 reception starts when receive-done is clear, receive enable set and the transmitter idle with nothing queued.
// - Other modes start receiving on a start bit when receive enable set.
// - Control bit 7 shows upper mode bit or framing error per view select.
// - Framing error sets on a missing stop bit and stays until software clears.
// - Control register layout: flags in bits 1:0, fields above, resets to zero.
// - Mode bits 00 shift, 01 8-bit variable, 10 9-bit fixed, 11 9-bit variable.
// - Multiprocessor enable suppresses receive-done on ninth bit 0 in nine-bit modes, or on bad stop in mode 1.
`timescale 1ns/1ps
module fmsp_serial_port #(
  parameter int M0_DIV = fmsp_pkg::M0_DIV,
  parameter int OVS    = fmsp_pkg::OVS_RATE
) (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       t1_ovf_i,
  input  wire logic       rxd_i,
  output logic            rxd_o,
  output logic            rxd_oe_o,
  output logic            txd_o,
  output logic            tx_ready_o
);
  generate if (M0_DIV < 4 || M0_DIV > 8 || OVS < 4 || OVS > 16) begin : g_bad
    $error("fmsp_serial_port: divider parameters out of range");
  end endgenerate

  // Register fields
  logic mode_hi_reg, mode_lo_reg, mp_en_reg, ren_reg, tx_ninth_reg, rx_ninth_reg;
  logic tx_done_reg, rx_done_reg, ferr_reg;
  logic rate_sel_reg, view_sel_reg;
  logic [7:0] rx_hold_reg;
  logic [7:0] rdata_reg;
  logic [7:0] ctrl_view;
  logic [1:0] mode;
  logic       nine;
  logic       ctrl_wr, buf_wr, pwr_wr;
  // Pin side
  logic       rxd_meta_reg, rxd_s_reg, rxd_prev_reg;
  logic       txd_reg, rxd_out_reg, rxd_oe_reg;
  // Rate generation
  logic       base_pulse, half_reg, tick16;
  logic [2:0] m0_ph_reg;
  logic       m0_last, m0_sample;
  // Transmit path
  fmsp_pkg::fmsp_tx_st_t tx_st_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0]  tx_cnt_reg, tx_ph_reg;
  logic        tx_load, tx_fin, tx_bit_end;
  logic        fifo_valid, fifo_ready;
  logic [7:0]  fifo_data;
  // Receive path
  fmsp_pkg::fmsp_rx_st_t rx_st_reg;
  logic [9:0]  rx_sh_reg, rx_nv;
  logic [3:0]  rx_cnt_reg, rx_ph_reg;
  logic        rx_mid, rx_m0_go, rx_async_go;
  logic        rx_async_fin, rx_m0_fin, rx_stop, rx_suppress, rx_accept;
  logic [7:0]  rx_data;

  assign mode    = {mode_hi_reg, mode_lo_reg};
  assign nine    = mode_hi_reg;
  assign ctrl_wr = sfr_wr_i && sfr_addr_i == fmsp_pkg::CTRL_ADDR;
  assign buf_wr  = sfr_wr_i && sfr_addr_i == fmsp_pkg::BUF_ADDR;
  assign pwr_wr  = sfr_wr_i && sfr_addr_i == fmsp_pkg::PWR_ADDR;

  // Receive pin passes two flops before any logic reads it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rxd_meta_reg <= 1'b1;
      rxd_s_reg    <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd_i;
      rxd_s_reg    <= rxd_meta_reg;
      rxd_prev_reg <= rxd_s_reg;
    end
  end

  // 16x tick: timer 1 overflow in modes 1 and 3, CPU clock in mode 2
  assign base_pulse = (mode == fmsp_pkg::MODE_9FIX) ? 1'b1 : t1_ovf_i;
  assign tick16     = base_pulse && (rate_sel_reg || half_reg);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      half_reg <= 1'b0;
    end else if (base_pulse) begin
      half_reg <= !half_reg;
    end
  end

  // Mode 0 bit timer, shared since mode 0 transmit and receive use the same pins
  assign m0_last   = m0_ph_reg == 3'(M0_DIV - 1);
  assign m0_sample = m0_ph_reg == 3'(M0_DIV / 2);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || (tx_st_reg != fmsp_pkg::TX_SHIFT0 && rx_st_reg != fmsp_pkg::RX_SHIFT0)) begin
      m0_ph_reg <= 3'h0;
    end else begin
      m0_ph_reg <= m0_last ? 3'h0 : m0_ph_reg + 3'h1;
    end
  end

  // every buffer write is queued for transmission; a full queue drops it
  fmsp_buf2 #(
    .WIDTH (8)
  ) u_tx_buf (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (buf_wr),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (sfr_wdata_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );

  // Mode 0 transmit waits while a mode 0 reception owns the pins
  assign tx_load    = fifo_valid && tx_st_reg == fmsp_pkg::TX_IDLE && rx_st_reg != fmsp_pkg::RX_SHIFT0;
  assign fifo_ready = tx_load;
  assign tx_bit_end = (tx_st_reg == fmsp_pkg::TX_SHIFT0 && m0_last) ||
                      (tx_st_reg == fmsp_pkg::TX_ASYNC && tick16 && tx_ph_reg == 4'(OVS - 1));
  assign tx_fin     = tx_bit_end && tx_cnt_reg == 4'h1;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_st_reg  <= fmsp_pkg::TX_IDLE;
      tx_sh_reg  <= 11'h7ff;
      tx_cnt_reg <= 4'h0;
      tx_ph_reg  <= 4'h0;
    end else begin
      unique case (tx_st_reg)
        fmsp_pkg::TX_IDLE: begin
          tx_ph_reg <= 4'h0;
          if (tx_load && mode == fmsp_pkg::MODE_SHIFT) begin
            tx_st_reg  <= fmsp_pkg::TX_SHIFT0;
            tx_sh_reg  <= {3'h7, fifo_data};
            tx_cnt_reg <= fmsp_pkg::M0_BITS;
          end else if (tx_load) begin
            // start low, data, ninth bit or stop, stop high
            tx_st_reg  <= fmsp_pkg::TX_ASYNC;
            tx_sh_reg  <= {1'b1, nine ? tx_ninth_reg : 1'b1, fifo_data, 1'b0};
            tx_cnt_reg <= nine ? fmsp_pkg::FRAME_9 : fmsp_pkg::FRAME_8;
          end
        end
        fmsp_pkg::TX_SHIFT0, fmsp_pkg::TX_ASYNC: begin
          if (tx_st_reg == fmsp_pkg::TX_ASYNC && tick16) begin
            tx_ph_reg <= (tx_ph_reg == 4'(OVS - 1)) ? 4'h0 : tx_ph_reg + 4'h1;
          end
          if (tx_bit_end) begin
            tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            if (tx_fin) begin
              tx_st_reg <= fmsp_pkg::TX_IDLE;
            end
          end
        end
        default: tx_st_reg <= fmsp_pkg::TX_IDLE;
      endcase
    end
  end

  // Receive decode
  assign rx_nv        = {rxd_s_reg, rx_sh_reg[9:1]};
  assign rx_mid       = tick16 && rx_ph_reg == 4'(OVS / 2 - 1);
  assign rx_stop      = rxd_s_reg;
  assign rx_m0_go     = mode == fmsp_pkg::MODE_SHIFT && ren_reg && !rx_done_reg &&
                        tx_st_reg == fmsp_pkg::TX_IDLE && !tx_load;
  // falling edge of the line starts an asynchronous reception
  assign rx_async_go  = mode != fmsp_pkg::MODE_SHIFT && ren_reg && rxd_prev_reg && !rxd_s_reg;
  assign rx_async_fin = rx_st_reg == fmsp_pkg::RX_DATA && rx_mid &&
                        rx_cnt_reg == (nine ? fmsp_pkg::RX_LAST_9 : fmsp_pkg::RX_LAST_8);
  assign rx_m0_fin    = rx_st_reg == fmsp_pkg::RX_SHIFT0 && m0_sample && rx_cnt_reg == fmsp_pkg::M0_LAST;
  assign rx_suppress  = mp_en_reg && (nine ? !rx_nv[8] : !rx_stop);
  assign rx_accept    = rx_m0_fin || (rx_async_fin && !rx_suppress);
  assign rx_data      = rx_m0_fin ? rx_nv[9:2] : (nine ? rx_nv[7:0] : rx_nv[8:1]);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_st_reg  <= fmsp_pkg::RX_IDLE;
      rx_sh_reg  <= 10'h000;
      rx_cnt_reg <= 4'h0;
      rx_ph_reg  <= 4'h0;
    end else begin
      if (tick16) begin
        rx_ph_reg <= (rx_ph_reg == 4'(OVS - 1)) ? 4'h0 : rx_ph_reg + 4'h1;
      end
      unique case (rx_st_reg)
        fmsp_pkg::RX_IDLE: begin
          rx_cnt_reg <= 4'h0;
          rx_ph_reg  <= 4'h0;
          if (rx_m0_go) begin
            rx_st_reg <= fmsp_pkg::RX_SHIFT0;
          end else if (rx_async_go) begin
            rx_st_reg <= fmsp_pkg::RX_START;
          end
        end
        fmsp_pkg::RX_SHIFT0: begin
          if (m0_sample) begin
            rx_sh_reg  <= rx_nv;
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_m0_fin) begin
              rx_st_reg <= fmsp_pkg::RX_IDLE;
            end
          end
        end
        fmsp_pkg::RX_START: begin
          // A start bit that is high again at mid-bit was a glitch
          if (rx_mid) begin
            rx_st_reg <= rxd_s_reg ? fmsp_pkg::RX_IDLE : fmsp_pkg::RX_DATA;
          end
        end
        fmsp_pkg::RX_DATA: begin
          if (rx_mid) begin
            rx_sh_reg  <= rx_nv;
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_async_fin) begin
              rx_st_reg <= fmsp_pkg::RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // receive holding register, overwritten by each accepted character
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_hold_reg <= 8'h00;
    end else if (rx_accept) begin
      rx_hold_reg <= rx_data;
    end
  end

  // control fields; hardware sets win over a software write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      {mode_hi_reg, mode_lo_reg, mp_en_reg, ren_reg, tx_ninth_reg, rx_ninth_reg, tx_done_reg,
       rx_done_reg} <= fmsp_pkg::CTRL_RST;
      ferr_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        mode_lo_reg  <= sfr_wdata_i[fmsp_pkg::MODE_LO_POS];
        mp_en_reg    <= sfr_wdata_i[fmsp_pkg::MP_EN_POS];
        ren_reg      <= sfr_wdata_i[fmsp_pkg::REN_POS];
        tx_ninth_reg <= sfr_wdata_i[fmsp_pkg::TX_NINTH_POS];
        // bit 7 writes whichever field is in view
        if (!view_sel_reg) begin
          mode_hi_reg <= sfr_wdata_i[fmsp_pkg::MODE_HI_POS];
        end
      end
      // ninth bit in nine-bit modes, stop bit in mode 1
      if (rx_async_fin && !rx_suppress) begin
        rx_ninth_reg <= nine ? rx_nv[8] : rx_stop;
      end else if (ctrl_wr) begin
        rx_ninth_reg <= sfr_wdata_i[fmsp_pkg::RX_NINTH_POS];
      end
      ferr_reg <= (rx_async_fin && !rx_stop) ||
                  ((ctrl_wr && view_sel_reg) ? sfr_wdata_i[fmsp_pkg::MODE_HI_POS] : ferr_reg);
      tx_done_reg <= tx_fin || (ctrl_wr ? sfr_wdata_i[fmsp_pkg::TX_DONE_POS] : tx_done_reg);
      rx_done_reg <= rx_accept || (ctrl_wr ? sfr_wdata_i[fmsp_pkg::RX_DONE_POS] : rx_done_reg);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      {rate_sel_reg, view_sel_reg} <= fmsp_pkg::PWR_RST;
    end else if (pwr_wr) begin
      rate_sel_reg <= sfr_wdata_i[fmsp_pkg::RATE_SEL_POS];
      view_sel_reg <= sfr_wdata_i[fmsp_pkg::VIEW_SEL_POS];
    end
  end

  assign ctrl_view = {view_sel_reg ? ferr_reg : mode_hi_reg, mode_lo_reg, mp_en_reg, ren_reg,
                      tx_ninth_reg, rx_ninth_reg, tx_done_reg, rx_done_reg};

  // read data, held between reads; unmapped addresses read zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        fmsp_pkg::CTRL_ADDR: rdata_reg <= ctrl_view;
        fmsp_pkg::BUF_ADDR:  rdata_reg <= rx_hold_reg;
        fmsp_pkg::PWR_ADDR:  rdata_reg <= {rate_sel_reg, view_sel_reg, 6'h00};
        default:             rdata_reg <= 8'h00;
      endcase
    end
  end
  assign sfr_rdata_o = rdata_reg;

  // pins: mode 0 clock idles high, low for the first half of each bit
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      txd_reg     <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg  <= 1'b0;
    end else begin
      if (tx_st_reg == fmsp_pkg::TX_SHIFT0 || rx_st_reg == fmsp_pkg::RX_SHIFT0) begin
        txd_reg <= m0_ph_reg >= 3'(M0_DIV / 2);
      end else begin
        txd_reg <= (tx_st_reg == fmsp_pkg::TX_ASYNC) ? tx_sh_reg[0] : 1'b1;
      end
      rxd_out_reg <= tx_sh_reg[0];
      rxd_oe_reg  <= tx_st_reg == fmsp_pkg::TX_SHIFT0;
    end
  end
  assign txd_o    = txd_reg;
  assign rxd_o    = rxd_out_reg;
  assign rxd_oe_o = rxd_oe_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_rx_overwrite: assert property (rx_accept |=> rx_hold_reg == $past(rx_data))
    else $error("receive holding register not loaded");
  a_buf_read: assert property ((sfr_rd_i && sfr_addr_i == fmsp_pkg::BUF_ADDR)
    |=> sfr_rdata_o == $past(rx_hold_reg))
    else $error("buffer read did not return receive register");
  a_m0_length: assert property ($rose(tx_st_reg == fmsp_pkg::TX_SHIFT0)
    |-> ##47 tx_st_reg == fmsp_pkg::TX_SHIFT0 ##1 tx_st_reg == fmsp_pkg::TX_IDLE)
    else $error("mode 0 transmit is not 48 clocks");
  a_m0_clock: assert property ((tx_st_reg == fmsp_pkg::TX_SHIFT0 && m0_ph_reg == 3'h0)
    |=> !txd_o ##3 txd_o)
    else $error("mode 0 shift clock phase wrong");
  a_start_bit: assert property ($rose(tx_st_reg == fmsp_pkg::TX_ASYNC) |=> !txd_o)
    else $error("async frame does not begin low");
  a_stop_stored: assert property ((rx_async_fin && !nine && !rx_suppress)
    |=> rx_ninth_reg == $past(rxd_s_reg))
    else $error("mode 1 stop bit not stored");
  a_ninth_tx: assert property ((tx_load && nine) |=> tx_sh_reg[9] == $past(tx_ninth_reg))
    else $error("ninth transmit bit not taken from field");
  a_ferr_sticky: assert property ((ferr_reg && !(ctrl_wr && view_sel_reg)) |=> ferr_reg)
    else $error("framing error cleared without software");
  a_mp_filter: assert property ((rx_async_fin && mp_en_reg && nine && !rx_nv[8] && !ctrl_wr)
    |=> rx_done_reg == $past(rx_done_reg))
    else $error("receive-done not suppressed");
  a_tx_done_set: assert property (tx_fin |=> tx_done_reg)
    else $error("transmit-done not set");

  c_duplex: cover property (tx_st_reg == fmsp_pkg::TX_ASYNC && rx_st_reg == fmsp_pkg::RX_DATA);
  c_m0_rx: cover property (rx_m0_fin);
  c_frame_err: cover property (rx_async_fin && !rx_stop);
  c_buf_full: cover property (!tx_ready_o && tx_st_reg != fmsp_pkg::TX_IDLE);
endmodule : fmsp_serial_port

// *** testbench/fmsp_peer.sv ***
// Behavioural remote serial peer driving the receive pin
`timescale 1ns/1ps
module fmsp_peer (
  input  wire logic sys_clk_i,
  input  wire logic sclk_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  task automatic send(input logic [10:0] bits, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (bc) @(posedge sys_clk_i);
    end
    // Back to idle so a bad stop bit cannot hide the next start edge
    line_o <= 1'b1;
    repeat (bc) @(posedge sys_clk_i);
  endtask : send
  // Mode 0 data, next bit after each clock rise
  task automatic supply_m0(input logic [7:0] d);
    line_o <= d[0];
    for (int i = 1; i < 9; i++) begin
      @(posedge sclk_i);
      line_o <= (i < 8) ? d[i] : ~d[7];
    end
  endtask : supply_m0
endmodule : fmsp_peer

// *** testbench/fmsp_serial_port_test.sv ***
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
module fmsp_serial_port_test;
  localparam int OVS = 8;
  localparam int M0D = 6;
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        t1_ovf  = 1'b0;
  logic  [1:0] ovf_div = 2'h0;
  logic  [7:0] addr    = 8'h00;
  logic  [7:0] wdata   = 8'h00;
  logic  [7:0] rdata;
  logic        rxd_o, rxd_oe, txd, tx_ready, peer_line, rxd_line;
  int          fail_count = 0;
  int          tests_run  = 0;
  integer      seed       = 32'hecc065a7;

  always #10 sys_clk = ~sys_clk;
  // Timer overflow every 4th clock feeds the variable-rate modes
  always @(posedge sys_clk) begin
    ovf_div <= ovf_div + 2'h1;
    t1_ovf  <= (ovf_div == 2'h3);
  end
  assign rxd_line = rxd_oe ? rxd_o : peer_line;

  fmsp_serial_port #(.M0_DIV(M0D), .OVS(OVS)) dut (
    .sys_clk_i(sys_clk), .srst_i(srst), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .t1_ovf_i(t1_ovf), .rxd_i(rxd_line),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd), .tx_ready_o(tx_ready));
  fmsp_peer peer (.sys_clk_i(sys_clk), .sclk_i(txd), .line_o(peer_line));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    #1 d = rdata;
  endtask : rd_reg

  function automatic int bclk(input logic [1:0] m, input logic s);
    if (m == fmsp_pkg::MODE_9FIX)
      return s ? OVS : 2 * OVS;
    return s ? 4 * OVS : 8 * OVS;
  endfunction : bclk

  function automatic logic [10:0] frame(input logic [1:0] m, input logic [7:0] d, input logic b9,
                                        input logic stp);
    return (m == fmsp_pkg::MODE_8VAR) ? {1'b0, stp, d, 1'b0} : {stp, b9, d, 1'b0};
  endfunction : frame

  // Samples each bit mid-way and returns at the stop bit sample
  task automatic get_tx(input int n, input int bc, output logic [10:0] b);
    int t;
    b = '0;
    t = 0;
    while (txd !== 1'b0 && t < 4000) begin
      @(negedge sys_clk);
      t++;
    end
    repeat (bc / 2) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      if (i < n - 1)
        repeat (bc) @(negedge sys_clk);
    end
  endtask : get_tx

  task automatic idle_chk(input string nm, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (txd !== 1'b1)
        bad++;
    end
    chk(nm, 11'h0, bad[10:0]);
  endtask : idle_chk

  task automatic m0_tx(output logic [7:0] d, output int per, output logic oe);
    int t, last, k;
    logic p;
    d = '0; per = 0; oe = 1'b1; p = 1'b1; last = 0; k = 0;
    for (t = 0; t < 300 && k < 8; t++) begin
      @(negedge sys_clk);
      if (txd === 1'b1 && p === 1'b0) begin
        d[k] = rxd_o;
        oe &= rxd_oe;
        per = t - last;
        last = t;
        k++;
      end
      p = txd;
    end
  endtask : m0_tx

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    logic [31:0] rnd;
    logic [10:0] got;
    logic [7:0]  v;
    int          n, bc, per;
    logic        oe;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    chk("txd idle", 11'h1, {10'h0, txd});
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("control reset", 11'h0, v);
    rd_reg(8'h42, v);
    chk("unmapped", 11'h0, v);
    for (int m = 1; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        bc = bclk(m[1:0], s[0]);
        n = (m == 1) ? 10 : 11;
        rnd = $random(seed);
        wr_reg(fmsp_pkg::PWR_ADDR, {s[0], 7'h0});
        wr_reg(fmsp_pkg::CTRL_ADDR, {m[1:0], 2'b01, rnd[16], 3'b000});
        fork
          begin
            wr_reg(fmsp_pkg::BUF_ADDR, rnd[7:0]);
            get_tx(n, bc, got);
          end
          peer.send(frame(m[1:0], rnd[15:8], rnd[17], 1'b1), n, bc);
        join
        repeat (bc) @(negedge sys_clk);
        chk("tx frame", frame(m[1:0], rnd[7:0], rnd[16], 1'b1), got);
        rd_reg(fmsp_pkg::CTRL_ADDR, v);
        chk("control", {3'h0, m[1:0], 2'b01, rnd[16], (m == 1) | rnd[17], 2'b11}, v);
        rd_reg(fmsp_pkg::BUF_ADDR, v);
        chk("rx byte", rnd[15:8], v);
      end
    end
    wr_reg(fmsp_pkg::PWR_ADDR, 8'h80);
    wr_reg(fmsp_pkg::CTRL_ADDR, 8'hb0);
    wr_reg(fmsp_pkg::PWR_ADDR, 8'hc0);
    peer.send(frame(2'h2, 8'h5a, 1'b0, 1'b1), 11, OVS);
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("address filter", 11'h30, v);
    peer.send(frame(2'h2, 8'ha5, 1'b1, 1'b0), 11, OVS);
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("framing set", 11'hb5, v);
    peer.send(frame(2'h2, 8'h3c, 1'b1, 1'b1), 11, OVS);
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("framing sticky", 11'hb5, v);
    rd_reg(fmsp_pkg::BUF_ADDR, v);
    chk("overwrite", 11'h3c, v);
    wr_reg(fmsp_pkg::CTRL_ADDR, 8'h30);
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("framing clear", 11'h30, v);
    wr_reg(fmsp_pkg::PWR_ADDR, 8'h80);
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("mode view", 11'hb0, v);
    // Fill the queue until it refuses, then drain three frames
    fork
      begin
        for (int k = 0; k < 4; k++)
          wr_reg(fmsp_pkg::BUF_ADDR, 8'h10 + k[7:0]);
        @(negedge sys_clk);
        chk("queue full", 11'h0, {10'h0, tx_ready});
      end
      for (int k = 0; k < 3; k++) begin
        get_tx(11, OVS, got);
        chk("queued frame", frame(2'h2, 8'h10 + k[7:0], 1'b0, 1'b1), got);
      end
    join
    idle_chk("dropped write", 12 * OVS);
    chk("queue empty", 11'h1, {10'h0, tx_ready});
    wr_reg(fmsp_pkg::CTRL_ADDR, 8'h00);
    rnd = $random(seed);
    wr_reg(fmsp_pkg::BUF_ADDR, rnd[7:0]);
    m0_tx(v, per, oe);
    chk("shift data", rnd[7:0], v);
    chk("shift period", 11'(M0D), 11'(per));
    chk("pin drive", 11'h1, {10'h0, oe});
    repeat (10) @(negedge sys_clk);
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("tx done", 11'h02, v);
    fork
      wr_reg(fmsp_pkg::CTRL_ADDR, 8'h10);
      peer.supply_m0(rnd[15:8]);
    join
    repeat (M0D) @(negedge sys_clk);
    rd_reg(fmsp_pkg::CTRL_ADDR, v);
    chk("shift rx done", 11'h11, v);
    rd_reg(fmsp_pkg::BUF_ADDR, v);
    chk("shift rx byte", rnd[15:8], v);
    idle_chk("rx held off", 60);
    print_verdict();
  end
endmodule : fmsp_serial_port_test
